// ### rtl/sadc_pkg.sv
// constants, types and helpers shared by the serial converter sequencer
package sadc_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int CS_SYNC_STAGES = 2;
	localparam int CS_SETUP_NS = 33;
	// device must open the link before the host's least setup time; sync stages already eat part of it
	localparam int CS_SETUP_CYC = (CS_SETUP_NS / CLK_PERIOD_NS) - CS_SYNC_STAGES;
	localparam int OSC_START_NS = 125;
	localparam int OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_HALF_PERIODS = 27; // 13.5 oscillator periods

	// ----------------------------------------------------------------
	// command word layout and codes
	// ----------------------------------------------------------------
	localparam int CMD_BITS = 8;
	localparam int ADDR_AT_RISE = 4;
	localparam int SAMPLE_START_FALL = 4;
	localparam int RES_BITS = 12;
	localparam int OUT_BITS = 16;
	localparam logic [3:0] CMD_POWER_DOWN = 4'hE;
	localparam logic [3:0] CMD_RESERVED = 4'hF;
	localparam logic [3:0] CFG_RESET = 4'h0;
	localparam logic [1:0] LEN_8 = 2'h1;
	localparam logic [1:0] LEN_16 = 2'h3;
	localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;

	// output format: D3-D2 length, D1 bit order, D0 polarity
	typedef struct packed {
		logic [1:0] len;
		logic lsb_first;
		logic twos_comp;
	} sadc_cfg_t;

	// signals toward the analog front end
	typedef struct packed {
		logic [3:0] sel;
		logic mux_en;
		logic power_down;
		logic sample_en;
		logic [11:0] dac_code;
	} sadc_afe_t;

	typedef enum logic [1:0] {S_IDLE, S_IO, S_STARTUP, S_CONV} sadc_state_t;

	// transfer length in clocks for a length select
	function automatic logic [4:0] len_of(input logic [1:0] sel);
		if (sel == LEN_8) begin
			len_of = 5'h08;
		end else if (sel == LEN_16) begin
			len_of = 5'h10;
		end else begin
			len_of = 5'h0C;
		end
	endfunction

endpackage

// ### rtl/sadc_seq.sv
// serial command, transfer and conversion sequencer of a successive-approximation converter
`timescale 1ns/10ps

// What this block does
// - select high: ignore inputs, output released
// - select low opens link, drives output
// - config nibble updates format, except command 1111b
// - command bits taken on first eight rising edges
// - later command bits ignored in long transfers
// - transfer is 8, 12 or 16 clocks
// - select held low: first bit at done rise
// - select toggled: first bit at select fall
// - further bits move on transfer clock falls
// - sampling starts at fourth falling edge
// - sampling ends and holds at last falling edge
// - conversion starts only after transfer completes
// - conversion timed by oscillator: 13.5 periods plus startup
// - done low during conversion, high after result load
// - last fall to done fall is constant
// - inputs ignored during select setup interval
// - selector picks channel, test or power-down, break-before-make
// - result saturates at full scale and zero
// - command codes map channels, tests, power-down, reserved
// - length, bit order and polarity encodings
// - sixteen-bit output pads four zero low bits
// - power-up: done high, configuration zero
module sadc_seq #(
	parameter int OSC_HALF_CYC = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic chip_select_n,
	input wire logic transfer_clock,
	input wire logic serial_cmd_in,
	input wire logic comp_above,
	output logic serial_result_out,
	output logic serial_result_oe_n,
	output logic conversion_done,
	output sadc_pkg::sadc_afe_t afe
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (OSC_HALF_CYC < 3 || OSC_HALF_CYC > 255) begin : g_bad_osc
		$error("OSC_HALF_CYC must be 3..255");
	end

	localparam logic [7:0] START_LAST = 8'(sadc_pkg::OSC_START_CYC - 1);
	localparam logic [7:0] HALF_LAST = 8'(OSC_HALF_CYC - 1);
	localparam logic [7:0] SETUP_LAST = 8'(sadc_pkg::CS_SETUP_CYC - 1);
	localparam logic [4:0] HALF_FINAL = 5'(sadc_pkg::CONV_HALF_PERIODS - 1);

	function automatic logic [4:0] bin2gray(input logic [4:0] b);
		bin2gray = b ^ (b >> 1);
	endfunction

	function automatic logic [4:0] gray2bin(input logic [4:0] g);
		logic [4:0] b;
		b[4] = g[4];
		for (int i = 3; i >= 0; i--) begin
			b[i] = b[i + 1] ^ g[i];
		end
		gray2bin = b;
	endfunction

	// ----------------------------------------------------------------
	// link domain, rising edges: command shift-in
	// ----------------------------------------------------------------
	logic link_hold_ff;
	logic [3:0] rise_cnt_ff, nxt_rise_cnt;
	logic [7:0] cmd_sr_ff, nxt_cmd_sr;
	logic [3:0] addr_ff, nxt_addr;

	// only the first eight rising edges shift; the address is frozen at the fourth
	always_comb begin
		nxt_rise_cnt = rise_cnt_ff;
		nxt_cmd_sr = cmd_sr_ff;
		nxt_addr = addr_ff;
		if (rise_cnt_ff < 4'(sadc_pkg::CMD_BITS)) begin
			nxt_cmd_sr = {cmd_sr_ff[6:0], serial_cmd_in};
			nxt_rise_cnt = rise_cnt_ff + 4'h1;
			if (rise_cnt_ff == 4'(sadc_pkg::ADDR_AT_RISE - 1)) begin
				nxt_addr = {cmd_sr_ff[2:0], serial_cmd_in};
			end
		end
	end

	// held in reset whenever the link is closed, so select-high ignores the clock
	always_ff @(posedge transfer_clock or posedge link_hold_ff) begin
		if (link_hold_ff) begin
			rise_cnt_ff <= 4'h0;
			cmd_sr_ff <= 8'h00;
			addr_ff <= 4'h0;
		end else begin
			rise_cnt_ff <= nxt_rise_cnt;
			cmd_sr_ff <= nxt_cmd_sr;
			addr_ff <= nxt_addr;
		end
	end

	// ----------------------------------------------------------------
	// link domain, falling edges: edge counter, gray coded for crossing
	// ----------------------------------------------------------------
	logic [4:0] fall_cnt_ff, nxt_fall_cnt;
	logic [4:0] fall_gray_ff;

	// saturates at sixteen; extra clocks cannot wrap the count
	always_comb begin
		nxt_fall_cnt = fall_cnt_ff;
		if (fall_cnt_ff < 5'(sadc_pkg::OUT_BITS)) begin
			nxt_fall_cnt = fall_cnt_ff + 5'h01;
		end
	end

	always_ff @(negedge transfer_clock or posedge link_hold_ff) begin
		if (link_hold_ff) begin
			fall_cnt_ff <= 5'h00;
			fall_gray_ff <= 5'h00;
		end else begin
			fall_cnt_ff <= nxt_fall_cnt;
			fall_gray_ff <= bin2gray(nxt_fall_cnt);
		end
	end

	// ----------------------------------------------------------------
	// synchronisers into clk
	// ----------------------------------------------------------------
	logic cs_meta_ff, cs_sync_ff, comp_meta_ff, comp_sync_ff;
	logic [4:0] fall_meta_ff, fall_sync_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			cs_meta_ff <= 1'b1;
			cs_sync_ff <= 1'b1;
			comp_meta_ff <= 1'b0;
			comp_sync_ff <= 1'b0;
			fall_meta_ff <= 5'h00;
			fall_sync_ff <= 5'h00;
		end else begin
			cs_meta_ff <= chip_select_n;
			cs_sync_ff <= cs_meta_ff;
			comp_meta_ff <= comp_above;
			comp_sync_ff <= comp_meta_ff;
			fall_meta_ff <= fall_gray_ff;
			fall_sync_ff <= fall_meta_ff;
		end
	end

	// ----------------------------------------------------------------
	// sequencer: setup, transfer, startup, conversion
	// ----------------------------------------------------------------
	sadc_pkg::sadc_state_t state_ff, nxt_state;
	sadc_pkg::sadc_cfg_t cfg_ff, nxt_cfg;
	logic [7:0] tick_ff, nxt_tick;
	logic [4:0] half_ff, nxt_half;
	logic [11:0] result_ff, nxt_result;
	logic [11:0] dac_ff, nxt_dac;
	logic done_ff, nxt_done;
	logic nxt_link_hold;
	logic [4:0] fall_bin, frame_len;
	logic io_done;

	// the command word is read only once eight falls have been seen; it stopped moving at the eighth rise
	assign fall_bin = gray2bin(fall_sync_ff);
	assign frame_len = (cmd_sr_ff[7:4] == sadc_pkg::CMD_RESERVED) ? sadc_pkg::len_of(cfg_ff.len)
		: sadc_pkg::len_of(cmd_sr_ff[3:2]);
	assign io_done = (state_ff == sadc_pkg::S_IO) && (fall_bin >= 5'h08) && (fall_bin == frame_len);

	always_comb begin
		nxt_state = state_ff;
		nxt_cfg = cfg_ff;
		nxt_tick = tick_ff;
		nxt_half = half_ff;
		nxt_result = result_ff;
		nxt_dac = dac_ff;
		nxt_done = done_ff;
		case (state_ff)
			sadc_pkg::S_IDLE: begin
				nxt_tick = 8'h00;
				if (!cs_sync_ff) begin
					nxt_tick = tick_ff + 8'h01;
					if (tick_ff >= SETUP_LAST) begin
						nxt_state = sadc_pkg::S_IO;
						nxt_tick = 8'h00;
					end
				end
			end
			sadc_pkg::S_IO: begin
				if (cs_sync_ff) begin
					nxt_state = sadc_pkg::S_IDLE;
				end else if (io_done) begin
					nxt_state = sadc_pkg::S_STARTUP;
					nxt_done = 1'b0;
					nxt_tick = 8'h00;
					if (cmd_sr_ff[7:4] != sadc_pkg::CMD_RESERVED) begin
						nxt_cfg = sadc_pkg::sadc_cfg_t'(cmd_sr_ff[3:0]);
					end
				end
			end
			sadc_pkg::S_STARTUP: begin
				// oscillator start-up delay
				nxt_tick = tick_ff + 8'h01;
				if (tick_ff == START_LAST) begin
					nxt_state = sadc_pkg::S_CONV;
					nxt_tick = 8'h00;
					nxt_half = 5'h00;
					nxt_dac = sadc_pkg::SAR_FIRST_TRIAL;
				end
			end
			sadc_pkg::S_CONV: begin
				// tick_ff counts one half period of internal_conv_osc
				nxt_tick = tick_ff + 8'h01;
				if (tick_ff == HALF_LAST) begin
					nxt_tick = 8'h00;
					nxt_half = half_ff + 5'h01;
					// one trial per full period; comparator high keeps the bit, so codes clip at the rails
					if (half_ff[0] && half_ff[4:1] < 4'(sadc_pkg::RES_BITS)) begin
						for (int b = 0; b < sadc_pkg::RES_BITS; b++) begin
							if (4'(b) == 4'(sadc_pkg::RES_BITS - 1) - half_ff[4:1]) begin
								nxt_dac[b] = comp_sync_ff;
								if (b > 0) begin
									nxt_dac[b - 1] = 1'b1;
								end
							end
						end
					end
					if (half_ff == HALF_FINAL) begin
						nxt_result = dac_ff;
						nxt_done = 1'b1;
						nxt_state = cs_sync_ff ? sadc_pkg::S_IDLE : sadc_pkg::S_IO;
					end
				end
			end
			default: begin
				nxt_state = sadc_pkg::S_IDLE;
			end
		endcase
		nxt_link_hold = (nxt_state != sadc_pkg::S_IO);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= sadc_pkg::S_IDLE;
			cfg_ff <= sadc_pkg::CFG_RESET;
			tick_ff <= 8'h00;
			half_ff <= 5'h00;
			result_ff <= 12'h000;
			dac_ff <= 12'h000;
			done_ff <= 1'b1;
			link_hold_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			cfg_ff <= nxt_cfg;
			tick_ff <= nxt_tick;
			half_ff <= nxt_half;
			result_ff <= nxt_result;
			dac_ff <= nxt_dac;
			done_ff <= nxt_done;
			link_hold_ff <= nxt_link_hold;
		end
	end

	// ----------------------------------------------------------------
	// result shift-out
	// ----------------------------------------------------------------
	logic out_ff, nxt_out, oe_n_ff;
	logic [15:0] out_word;
	logic [4:0] out_idx, out_len;
	logic [5:0] out_pos;

	// the bit index follows the falls; a new result shows its first bit the edge done rises
	always_comb begin
		out_word = {nxt_result[11] ^ cfg_ff.twos_comp, nxt_result[10:0], 4'h0};
		out_len = sadc_pkg::len_of(cfg_ff.len);
		out_idx = (state_ff == sadc_pkg::S_IO) ? fall_bin : 5'h00;
		if (cfg_ff.lsb_first) begin
			out_pos = 6'h10 - {1'b0, out_len} + {1'b0, out_idx};
		end else begin
			out_pos = 6'h0F - {1'b0, out_idx};
		end
		nxt_out = (out_idx < out_len) ? out_word[out_pos[3:0]] : 1'b0;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			out_ff <= 1'b0;
			oe_n_ff <= 1'b1;
		end else begin
			out_ff <= nxt_out;
			oe_n_ff <= cs_sync_ff;
		end
	end

	// ----------------------------------------------------------------
	// input selector and sampling switch
	// ----------------------------------------------------------------
	logic [1:0] mux_step_ff, nxt_mux_step;
	logic mux_used_ff, nxt_mux_used;
	sadc_pkg::sadc_afe_t afe_ff, nxt_afe;

	// open the switch, then move the select, then close it again unless power-down or reserved is selected
	always_comb begin
		nxt_afe = afe_ff;
		nxt_mux_step = 2'h0;
		nxt_mux_used = mux_used_ff && (state_ff == sadc_pkg::S_IO);
		if (state_ff == sadc_pkg::S_IO && !mux_used_ff && fall_bin >= 5'(sadc_pkg::SAMPLE_START_FALL)) begin
			nxt_afe.mux_en = 1'b0;
			nxt_mux_step = 2'h1;
			nxt_mux_used = 1'b1;
		end else if (mux_step_ff == 2'h1) begin
			nxt_afe.sel = addr_ff;
			nxt_afe.power_down = (addr_ff == sadc_pkg::CMD_POWER_DOWN);
			nxt_mux_step = 2'h2;
		end else if (mux_step_ff == 2'h2) begin
			nxt_afe.mux_en = !afe_ff.power_down && (afe_ff.sel != sadc_pkg::CMD_RESERVED);
		end
		// track from the fourth fall; held once the last fall is counted
		nxt_afe.sample_en = (state_ff == sadc_pkg::S_IO) && !io_done
			&& (fall_bin >= 5'(sadc_pkg::SAMPLE_START_FALL)) && ((fall_bin < 5'h08) || (fall_bin < frame_len));
		nxt_afe.dac_code = nxt_dac;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			afe_ff <= '0;
			mux_step_ff <= 2'h0;
			mux_used_ff <= 1'b0;
		end else begin
			afe_ff <= nxt_afe;
			mux_step_ff <= nxt_mux_step;
			mux_used_ff <= nxt_mux_used;
		end
	end

	assign serial_result_out = out_ff;
	assign serial_result_oe_n = oe_n_ff;
	assign conversion_done = done_ff;
	assign afe = afe_ff;

	// ----------------------------------------------------------------
	// assertions and covers
	// ----------------------------------------------------------------
	localparam int CONV_TOTAL = sadc_pkg::OSC_START_CYC + sadc_pkg::CONV_HALF_PERIODS * OSC_HALF_CYC;
	logic [11:0] low_cnt_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			low_cnt_ff <= 12'h000;
		end else begin
			low_cnt_ff <= done_ff ? 12'h000 : low_cnt_ff + 12'h001;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_hiz_deselected;
		cs_sync_ff |=> serial_result_oe_n;
	endproperty
	a_hiz_deselected: assert property (p_hiz_deselected) else $error("output driven while deselected");

	property p_drive_selected;
		!cs_sync_ff ##1 !cs_sync_ff |-> !serial_result_oe_n;
	endproperty
	a_drive_selected: assert property (p_drive_selected) else $error("output not driven while selected");

	property p_done_fixed_delay;
		io_done && !cs_sync_ff |=> !conversion_done && state_ff == sadc_pkg::S_STARTUP;
	endproperty
	a_done_fixed_delay: assert property (p_done_fixed_delay) else $error("done did not fall after last edge");

	property p_conv_length;
		$rose(conversion_done) |-> low_cnt_ff == 12'(CONV_TOTAL);
	endproperty
	a_conv_length: assert property (p_conv_length) else $error("conversion length wrong");

	property p_done_low_in_conv;
		(state_ff == sadc_pkg::S_STARTUP || state_ff == sadc_pkg::S_CONV) |-> !conversion_done;
	endproperty
	a_done_low_in_conv: assert property (p_done_low_in_conv) else $error("done high during conversion");

	property p_cfg_update;
		io_done && !cs_sync_ff && cmd_sr_ff[7:4] != sadc_pkg::CMD_RESERVED |=> cfg_ff == $past(cmd_sr_ff[3:0]);
	endproperty
	a_cfg_update: assert property (p_cfg_update) else $error("configuration not updated");

	property p_sample_held;
		io_done |=> !afe_ff.sample_en ##1 !afe_ff.sample_en;
	endproperty
	a_sample_held: assert property (p_sample_held) else $error("sampling not held at last edge");

	property p_break_before_make;
		$changed(afe_ff.sel) |-> !afe_ff.mux_en && !$past(afe_ff.mux_en);
	endproperty
	a_break_before_make: assert property (p_break_before_make) else $error("selector switched while closed");

	property p_no_conv_mid_frame;
		$fell(conversion_done) |-> $past(fall_bin) == $past(frame_len) && $past(fall_bin) >= 5'h08;
	endproperty
	a_no_conv_mid_frame: assert property (p_no_conv_mid_frame) else $error("conversion started mid transfer");

	c_conv_done: cover property ($rose(conversion_done));
	c_frame_16: cover property (io_done && frame_len == 5'h10);
	c_power_down: cover property ($rose(afe_ff.power_down));
	c_lsb_first: cover property (cfg_ff.lsb_first && $rose(conversion_done));

endmodule // sadc_seq

// ### tb/sadc_host.sv
// host serial port and analog input model facing the converter sequencer
`timescale 1ns/10ps
module sadc_host (
	output logic chip_select_n,
	output logic transfer_clock,
	output logic serial_cmd_in,
	output logic comp_above,
	input wire logic serial_result_out,
	input wire logic serial_result_oe_n,
	input wire logic conversion_done,
	input wire sadc_pkg::sadc_afe_t afe
);
	logic [11:0] vin [16];
	logic [15:0] word;
	logic [3:0] samp;
	logic [5:0] sw;
	logic line_in;
	logic in_frame;
	event got_ev;

	// analog side: selected input level against the trial code
	assign comp_above = vin[afe.sel] >= afe.dac_code;

	// a released result line has no keeper; reading it then gives the inverse, so a late enable shows up
	assign line_in = serial_result_oe_n ? ~serial_result_out : serial_result_out;

	// idle levels: select high, link clock parked low
	initial begin
		chip_select_n = 1'b1;
		transfer_clock = 1'b0;
		serial_cmd_in = 1'b0;
		in_frame = 1'b0;
		samp = 4'h0;
		vin[11] = 12'h800; // midpoint test level
		vin[12] = 12'h000;
		vin[13] = 12'hfff;
		vin[14] = 12'h000;
		vin[15] = 12'h000;
	end

	// one transfer of n clocks; select pulsed high first unless held low
	task automatic frame(input logic [7:0] cmd, input int n, input logic hold, input logic noise,
		input logic ab);
		int k;
		for (k = 0; k < 400 && conversion_done !== 1'b1; k++) #8;
		#40.3;
		if (!hold) begin
			chip_select_n = 1'b1;
			#48;
			chip_select_n = 1'b0;
			#70;
		end
		in_frame = 1'b1;
		word = 16'h0000;
		for (k = 0; k < n; k++) begin
			if (k < 8) serial_cmd_in = cmd[7 - k];
			else if (noise) serial_cmd_in = ~serial_cmd_in; // otherwise held
			#62.5;
			transfer_clock = 1'b1;
			word = {word[14:0], line_in};
			if (k == 0) samp[3] = serial_result_oe_n;
			if (k == 3) samp[2] = afe.sample_en;
			if (k == n - 1) samp[1] = afe.sample_en;
			if (k == n - 1) sw = {afe.mux_en, afe.power_down, afe.sel};
			#62.5;
			transfer_clock = 1'b0;
		end
		in_frame = 1'b0;
		#80;
		samp[0] = afe.sample_en;
		if (ab) begin
			chip_select_n = 1'b1;
			serial_cmd_in = ~serial_cmd_in;
		end else begin
			-> got_ev;
		end
	endtask
endmodule // sadc_host

// ### tb/tb_sadc_seq.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
module tb_sadc_seq;
	typedef struct packed {
		logic [15:0] w;
		logic [15:0] m;
		logic sc;
		logic [5:0] sw;
	} sadc_note_t;
	localparam int OSC_HALF = 4;
	localparam int DONE_LOW = sadc_pkg::OSC_START_CYC + sadc_pkg::CONV_HALF_PERIODS * OSC_HALF;
	logic clk, rst, chip_select_n, transfer_clock, serial_cmd_in, comp_above;
	logic serial_result_out, serial_result_oe_n, conversion_done;
	sadc_pkg::sadc_afe_t afe;
	int err_count, n_tests, n_conv, low_cnt, snap;
	sadc_note_t exp_q[$];
	logic [31:0] seed = 32'h0000_506f;
	logic [3:0] cfg;
	logic [11:0] res;
	logic res_ok;
	logic [3:0] cfg_tab [8] = '{4'h0, 4'hc, 4'h2, 4'h1, 4'he, 4'h4, 4'h8, 4'hf};

	sadc_seq #(.OSC_HALF_CYC(OSC_HALF)) dut_u (.clk(clk), .rst(rst), .chip_select_n(chip_select_n),
		.transfer_clock(transfer_clock), .serial_cmd_in(serial_cmd_in), .comp_above(comp_above),
		.serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n),
		.conversion_done(conversion_done), .afe(afe));
	sadc_host host_u (.chip_select_n(chip_select_n), .transfer_clock(transfer_clock),
		.serial_cmd_in(serial_cmd_in), .comp_above(comp_above), .serial_result_out(serial_result_out),
		.serial_result_oe_n(serial_result_oe_n), .conversion_done(conversion_done), .afe(afe));

	// system clock
	initial clk = 1'b0;
	always #4 clk = ~clk;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// single status flags
	task automatic chk_flag(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// cycle and event counts
	task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("errors=%0d checks=%0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
	endfunction

	function automatic int blen(input logic [1:0] l);
		blen = (l == 2'b01) ? 8 : ((l == 2'b11) ? 16 : 12);
	endfunction

	// note the expected word of one transfer, run it, then update the model state
	task automatic run(input logic [7:0] cmd, input logic hold, input logic noise);
		sadc_note_t nt;
		int n;
		int lo;
		logic [15:0] w16;
		logic [3:0] c;
		c = (cmd[7:4] == 4'hf) ? cfg : cmd[3:0];
		n = blen(c[3:2]);
		lo = blen(cfg[3:2]);
		w16 = {res ^ {cfg[0], 11'h000}, 4'h0};
		nt = '0;
		for (int i = 0; i < n && i < lo; i++) begin
			nt.w[n - 1 - i] = cfg[1] ? w16[16 - lo + i] : w16[15 - i];
			nt.m[n - 1 - i] = res_ok;
		end
		nt.sc = cmd[7:4] < 4'he;
		nt.sw = {cmd[7:4] < 4'he, cmd[7:4] == 4'he, cmd[7:4]};
		exp_q.push_back(nt);
		host_u.frame(cmd, n, hold, noise, 1'b0);
		cfg = c;
		res_ok = cmd[7:4] < 4'he;
		res = (cmd[7:4] == 4'hb) ? 12'h800 : (cmd[7:4] == 4'hc) ? 12'h000 :
			(cmd[7:4] == 4'hd) ? 12'hfff : host_u.vin[cmd[7:4]];
	endtask

	// word monitor: each finished transfer is compared with the oldest note
	always @(host_u.got_ev) begin
		sadc_note_t nt;
		nt = exp_q.pop_front();
		chk(host_u.word & nt.m, nt.w & nt.m);
		chk_flag(host_u.samp[3], 1'b0);
		chk({10'h000, host_u.sw}, {10'h000, nt.sw});
		if (nt.sc) chk({12'h000, host_u.samp}, 16'h0002);
	end

	// conversion monitor: start outside a transfer, fixed low time of done
	always @(posedge clk) begin
		if (!rst && conversion_done === 1'b0) begin
			if (low_cnt == 0) chk_flag(host_u.in_frame, 1'b0);
			low_cnt <= low_cnt + 1;
		end else if (low_cnt != 0) begin
			chk_cnt(16'(low_cnt), 16'(DONE_LOW));
			n_conv <= n_conv + 1;
			low_cnt <= 0;
		end
	end

	// watchdog sized well above the expected run time
	initial begin
		#400_000;
		err_count++;
		conclude();
	end

	// main sequence
	initial begin
		rst = 1'b1;
		err_count = 0;
		n_tests = 0;
		n_conv = 0;
		low_cnt = 0;
		cfg = 4'h0;
		res = 12'h000;
		res_ok = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		@(posedge clk);
		#1;
		chk_flag(conversion_done, 1'b1);
		chk_flag(serial_result_oe_n, 1'b1);
		chk_flag(serial_result_out, 1'b0);
		for (int i = 0; i < 11; i++) begin
			seed = lfsr(seed);
			host_u.vin[i] = seed[11:0];
		end
		run(8'h00, 1'b0, 1'b0);
		for (int c = 0; c < 16; c++) run({c[3:0], cfg_tab[c % 8]}, c[0], c == 6);
		run(8'h30, 1'b0, 1'b0);
		host_u.frame(8'h30, 5, 1'b0, 1'b0, 1'b1);
		snap = n_conv;
		#48;
		chk_flag(serial_result_oe_n, 1'b1);
		repeat (200) @(posedge clk);
		chk_cnt(16'(n_conv), 16'(snap));
		run(8'h30, 1'b0, 1'b0);
		repeat (200) @(posedge clk);
		conclude();
	end
endmodule // tb_sadc_seq
